// ===== bench/ifm_conv_model.sv
// converter model that answers the monitor's sample strobes
`timescale 1ns/10ps
module ifm_conv_model (
  // clock and mux side
  input wire logic clk_i,
  input wire logic [2:0] mux_chan_i,
  input wire logic mux_sample_i,
  // per channel conditions to report
  input wire logic [7:0] open_i,
  input wire logic [7:0] under_i,
  input wire logic [7:0] over_i,
  input wire logic [7:0] acq_i,
  input wire logic [7:0] cal_i,
  input wire logic [7:0] short_i,
  input wire logic [7:0] big_i,
  input wire logic cj_i,
  input wire logic stall_i,
  input wire logic [3:0] dly_i,
  // result lines, qualified by valid
  output logic valid_o,
  output logic [5:0] flt_o,
  output logic [15:0] ohms_o,
  output logic signed [19:0] eu_o,
  output logic [15:0] data_o
);
  // outside an answer the lines show the inverse of the last answer, so a
  // monitor that samples without valid sees garbage rather than a lucky match
  initial begin
    valid_o = 1'b0;
    flt_o = 6'h3F;
    ohms_o = 16'hFFFF;
    eu_o = 20'shFFFFF;
    data_o = 16'hFFFF;
    forever begin
      @(posedge clk_i);
      #1;
      if (mux_sample_i && !stall_i) begin
        repeat (dly_i) begin
          @(posedge clk_i);
          #1;
        end
        valid_o = 1'b1;
        flt_o = {cj_i, cal_i[mux_chan_i], acq_i[mux_chan_i], over_i[mux_chan_i],
                 under_i[mux_chan_i], open_i[mux_chan_i]};
        ohms_o = short_i[mux_chan_i] ? 16'h0002 : 16'h0003;
        eu_o = big_i[mux_chan_i] ? 20'sh08000 : 20'sh07FFF;
        data_o = {8'hD0, 5'h00, mux_chan_i};
        @(posedge clk_i);
        #1;
        valid_o = 1'b0;
        flt_o = ~flt_o;
        ohms_o = ~ohms_o;
        eu_o = ~eu_o;
        data_o = ~data_o;
      end
    end
  end
endmodule

// ===== bench/tb_ifm_fault_monitor.sv
// self-checking bench of the input channel fault monitor
`timescale 1ns/10ps
module tb_ifm_fault_monitor;
  // short counts keep the run small
  localparam int SETTLE = 8;
  localparam int BLINK = 4;
  localparam int WDOG = 64;
  logic clk, rst_n, st_done, st_fail, fatal, rd_en, mux_smp, img_vld, mlamp, serr_vld, s_vld;
  logic p_cj, p_stall, sarm;
  logic [7:0] en, unity, fahr, oc, sel, clamp, p_open, p_under, p_over, p_acq, p_cal;
  logic [7:0] p_short, p_big, fcode;
  logic [7:0][4:0] ctype;
  logic [2:0] rd_ch, mux_chan, prev_ch;
  logic [15:0] img, serr, s_ohms, s_data;
  logic [3:0] p_dly;
  logic [5:0] s_flt;
  logic signed [19:0] s_eu;
  logic [15:0] exp_w [8];
  int error_cnt, cmp_count, scnt;

  ifm_fault_monitor #(.SETTLE_CYC(SETTLE), .BLINK_CYC(BLINK), .WDOG_CYC(WDOG)) DUT (
    .clk_i(clk), .reset_n_i(rst_n), .clk_en_i(1'b1),
    .selftest_done_i(st_done), .selftest_fail_i(st_fail), .fatal_i(fatal),
    .fatal_code_i(fcode), .slot_i(8'h03), .chan_enable_i(en), .cfg_type_i(ctype),
    .cfg_unity_eu_i(unity), .cfg_fahr_i(fahr), .cfg_oc_en_i(oc), .cfg_status_sel_i(sel),
    .sample_valid_i(s_vld), .sample_open_i(s_flt[0]), .sample_under_i(s_flt[1]),
    .sample_over_i(s_flt[2]), .sample_acq_bad_i(s_flt[3]), .sample_autocal_fail_i(s_flt[4]),
    .cold_junction_sensor_open_i(s_flt[5]), .sample_ohms_i(s_ohms), .sample_eu_i(s_eu),
    .sample_data_i(s_data), .rd_en_i(rd_en), .rd_chan_i(rd_ch), .mux_chan_o(mux_chan),
    .mux_sample_o(mux_smp), .image_word_o(img), .image_valid_o(img_vld), .mod_lamp_o(mlamp),
    .chan_lamp_o(clamp), .slot_error_o(serr), .slot_error_valid_o(serr_vld));

  ifm_conv_model conv (
    .clk_i(clk), .mux_chan_i(mux_chan), .mux_sample_i(mux_smp), .open_i(p_open),
    .under_i(p_under), .over_i(p_over), .acq_i(p_acq), .cal_i(p_cal), .short_i(p_short),
    .big_i(p_big), .cj_i(p_cj), .stall_i(p_stall), .dly_i(p_dly), .valid_o(s_vld),
    .flt_o(s_flt), .ohms_o(s_ohms), .eu_o(s_eu), .data_o(s_data));

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // reset, then finish power-up with a passing or failing self-test
  task automatic do_reset(input logic fail);
    rst_n = 1'b0;
    st_done = 1'b0;
    st_fail = fail;
    fatal = 1'b0;
    repeat (6) @(posedge clk);
    check("rst_lamps", {7'h00, mlamp, clamp}, 16'h0000);
    #1;
    rst_n = 1'b1;
    repeat (3) @(posedge clk);
    #1;
    check("pwr_lamps", {7'h00, mlamp, clamp}, 16'h0000);
    st_done = 1'b1;
    @(posedge clk);
    #1;
    // lamp and a fail report stand right after the edge that takes done
    st_done = 1'b0;
    check("mod_lamp", {15'h0, mlamp}, {15'h0, !fail});
  endtask

  task automatic wait_serr(input logic [15:0] exp, input int lim);
    int n;
    n = 0;
    while (serr_vld !== 1'b1 && n < lim) begin
      @(posedge clk);
      #1;
      n++;
    end
    check("serr_vld", {15'h0, serr_vld}, 16'h0001);
    check("serr_code", serr, exp);
  endtask

  // image read: answer stands between the first and second edge after the request edge
  task automatic rd(input logic [2:0] ch, input logic [15:0] exp, input logic vld);
    @(posedge clk);
    #1;
    rd_en = 1'b1;
    rd_ch = ch;
    @(posedge clk);
    #1;
    rd_en = 1'b0;
    @(posedge clk);
    #1;
    check("img_vld", {15'h0, img_vld}, {15'h0, vld});
    if (vld) check("img_word", img, exp);
  endtask

  // run the mux until it wraps to channel 0 twice, so every channel is scanned with the new setup
  task automatic wait_rot();
    int n;
    n = 0;
    repeat (2) begin
      while (mux_chan !== 3'h7 && n < 4000) begin
        @(posedge clk);
        #1;
        n++;
      end
      while (mux_chan !== 3'h0 && n < 4000) begin
        @(posedge clk);
        #1;
        n++;
      end
    end
    check("rotation", {15'h0, n < 4000}, 16'h0001);
  endtask

  task automatic lamps(input logic [7:0] e_on, input logic [7:0] e_off);
    logic [7:0] on, off;
    on = 8'h00;
    off = 8'h00;
    repeat (4 * BLINK) begin
      @(posedge clk);
      #1;
      on |= clamp;
      off |= ~clamp;
    end
    check("lamp_on", {8'h00, on}, {8'h00, e_on});
    check("lamp_off", {8'h00, off}, {8'h00, e_off});
  endtask

  // ****************************************
  // clock, settle monitor, watchdog
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // counts edges from each mux switch to the sample strobe
  always @(posedge clk) begin
    #1;
    if (!rst_n || mux_chan !== prev_ch) begin
      scnt = 0;
      sarm = rst_n;
    end else begin
      scnt++;
    end
    prev_ch = mux_chan;
    if (mux_smp === 1'b1 && sarm) begin
      check("settle", scnt[15:0], 16'(SETTLE));
      sarm = 1'b0;
    end
  end

  // the whole run needs about a thousand cycles; this is far beyond it
  initial begin
    #100000;
    error_cnt++;
    summarize();
  end

  // ****************************************
  // tests
  // ****************************************
  initial begin
    error_cnt = 0;
    cmp_count = 0;
    sarm = 1'b0;
    prev_ch = 3'h0;
    rst_n = 1'b0;
    st_done = 1'b0;
    st_fail = 1'b0;
    fatal = 1'b0;
    fcode = 8'h92;
    rd_en = 1'b0;
    rd_ch = 3'h0;
    en = 8'hFF;
    ctype = {5'h01, 5'h0A, 5'h17, 5'h10, 5'h12, 5'h16, 5'h00, 5'h00};
    unity = 8'h90;
    fahr = 8'h80;
    oc = 8'h21;
    sel = 8'hFF;
    p_open = 8'h21;
    p_under = 8'h02;
    p_over = 8'h04;
    p_acq = 8'h00;
    p_cal = 8'h00;
    p_short = 8'h40;
    p_big = 8'h80;
    p_cj = 1'b0;
    p_stall = 1'b0;
    p_dly = 4'h0;
    #1;
    // every channel faulty in its own way, prompt converter
    do_reset(1'b0);
    wait_rot();
    exp_w = '{16'h1000, 16'h2000, 16'h4000, 16'h8000, 16'h8000, 16'h8000, 16'h1000, 16'h4000};
    for (int i = 0; i < 8; i++) begin
      rd(3'(i), exp_w[i], 1'b1);
    end
    lamps(8'hFF, 8'hFF);
    // faults cleared or moved, boundaries held, one channel off, slow converter
    ctype = {5'h01, 5'h0A, 5'h00, 5'h11, 5'h1D, 5'h0A, 5'h00, 5'h00};
    en = 8'hBF;
    unity = 8'h80;
    oc = 8'h10;
    sel = 8'hDF;
    p_open = 8'h10;
    p_under = 8'h00;
    p_over = 8'h00;
    p_acq = 8'h01;
    p_cal = 8'h02;
    p_short = 8'h00;
    p_big = 8'h00;
    p_dly = 4'h5;
    wait_rot();
    exp_w = '{16'h8000, 16'h8000, 16'h0000, 16'h8000, 16'h0000, 16'hD005, 16'h0000, 16'h0000};
    for (int i = 0; i < 8; i++) begin
      rd(3'(i), exp_w[i], 1'b1);
    end
    lamps(8'hBF, 8'h4B);
    // cold junction sensor lost: thermocouple channels report open
    p_cj = 1'b1;
    sel = 8'hFF;
    wait_rot();
    exp_w = '{16'h9000, 16'h9000, 16'h0000, 16'h8000, 16'h0000, 16'h1000, 16'h0000, 16'h1000};
    for (int i = 0; i < 8; i++) begin
      rd(3'(i), exp_w[i], 1'b1);
    end
    // non-recoverable fault: report, lamps dark, reads refused
    fatal = 1'b1;
    wait_serr(16'h0392, 8);
    check("fatal_lamps", {7'h00, mlamp, clamp}, 16'h0000);
    rd(3'h0, 16'h0000, 1'b0);
    // failing self-test
    do_reset(1'b1);
    wait_serr(16'h0350, 2);
    // converter never answers: watchdog report
    p_stall = 1'b1;
    do_reset(1'b0);
    wait_serr(16'h0371, 3 * WDOG);
    check("wdog_lamp", {15'h0, mlamp}, 16'h0000);
    // unknown fatal code falls back to the top of the first band
    fcode = 8'h60;
    do_reset(1'b0);
    fatal = 1'b1;
    wait_serr(16'h035E, 8);
    summarize();
  end
endmodule

// ===== rtl/ifm_data_mem.sv
// eight conversion data words with a registered read port
`timescale 1ns/10ps
module ifm_data_mem (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic clk_en_i,
  // access port
  ifm_mem_if.mem m
);
  ifm_pkg::ifm_mem_s s_reg;
  ifm_pkg::ifm_mem_s s_next;

  // read first: a read returns the old word on a same-address collision
  always_comb begin
    s_next = s_reg;
    if (m.wr_en) begin
      s_next.word[m.wr_addr] = m.wr_data;
    end
    if (m.rd_en) begin
      s_next.rdata = s_reg.word[m.rd_addr];
    end
  end

  // state register
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s_reg <= '0;
    end else if (clk_en_i) begin
      s_reg <= s_next;
    end
  end

  assign m.rd_data = s_reg.rdata;
endmodule

// ===== rtl/ifm_fault_monitor.sv
// fault monitor, lamps and image words of the eight-channel input module
// Notes on behaviour
// R1: module lamp lit while healthy, dark on fault
// R2: channel lamp steady when ok, blinks on fault
// R3: channel lamp dark in power-up or disabled
// R4: failed power-up self-test leaves module lamp dark
// R5: validate config on enable, then check each scan
// R6: failed diagnostic sets flag and blinks lamp
// R7: flags and blinking clear when fault goes
// R8: clearing enable resets all channel flags
// R9: bit 12 open, 13 under, 14 over
// R10: bit 15 marks diagnostic or channel error
// R11: open test if enabled; cold junction always
// R12: no open test on voltage, 0-20 mA ranges
// R13: resistance thermometer below 3 ohms is open
// R14: under and over range every enabled scan
// R15: unity units Fahrenheit over 32767 is over
// R16: codes 10010, 11101 invalid on channels 0-3
// R17: unity units with mV, V, mA is error
// R18: open detect with V or mA is error
// R19: bad acquisition or autocal check is error
// R20: fatal fault: silent, channels off, words zeroed
// R21: slot code is slot byte plus error byte
// R22: 3 ms settling after each mux switch
// R23: per channel, image returns data or status
// R24: missing cold junction opens all thermocouples
// R25: shared counter makes the one hertz blink
// R26: flags update at the end of each scan
`timescale 1ns/10ps
`include "ifm_map.svh"
module ifm_fault_monitor #(
  parameter int unsigned SETTLE_CYC = `IFM_SETTLE_CYC,
  parameter int unsigned BLINK_CYC = `IFM_BLINK_CYC,
  parameter int unsigned WDOG_CYC = `IFM_WDOG_CYC
) (
  // clock, reset, enable
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic clk_en_i,
  // self-test and module faults
  input wire logic selftest_done_i,
  input wire logic selftest_fail_i,
  input wire logic fatal_i,
  input wire logic [7:0] fatal_code_i,
  input wire logic [7:0] slot_i,
  // channel configuration
  input wire logic [7:0] chan_enable_i,
  input wire logic [7:0][4:0] cfg_type_i,
  input wire logic [7:0] cfg_unity_eu_i,
  input wire logic [7:0] cfg_fahr_i,
  input wire logic [7:0] cfg_oc_en_i,
  input wire logic [7:0] cfg_status_sel_i,
  // scan results for the channel on mux_chan_o
  input wire logic sample_valid_i,
  input wire logic sample_open_i,
  input wire logic sample_under_i,
  input wire logic sample_over_i,
  input wire logic sample_acq_bad_i,
  input wire logic sample_autocal_fail_i,
  input wire logic cold_junction_sensor_open_i,
  input wire logic [15:0] sample_ohms_i,
  input wire logic signed [19:0] sample_eu_i,
  input wire logic [15:0] sample_data_i,
  // image word read
  input wire logic rd_en_i,
  input wire logic [2:0] rd_chan_i,
  // multiplexer control
  output logic [2:0] mux_chan_o,
  output logic mux_sample_o,
  // image word answer
  output logic [15:0] image_word_o,
  output logic image_valid_o,
  // lamps and slot error
  output logic mod_lamp_o,
  output logic [7:0] chan_lamp_o,
  output logic [15:0] slot_error_o,
  output logic slot_error_valid_o
);
  localparam int CW = `IFM_CNT_W;
  localparam int BW = `IFM_BLK_W;

  ifm_pkg::ifm_state_s s_reg;
  ifm_pkg::ifm_state_s s_next;
  ifm_mem_if mif ();

  // ************************************************************
  // input type classes
  // ************************************************************
  function automatic logic is_vi(input logic [4:0] t);
    return t == `IFM_TYPE_V0_5 || t == `IFM_TYPE_V1_5 || t == `IFM_TYPE_V0_10 ||
           t == `IFM_TYPE_PM10V || t == `IFM_TYPE_MA0_20;
  endfunction

  // no open test on these ranges [R12]
  function automatic logic oc_app(input logic [4:0] t);
    return !(is_vi(t) || t == `IFM_TYPE_PM2V);
  endfunction

  // configuration checks done when a channel comes up and again on every scan
  function automatic logic cfg_bad(input logic [2:0] c);
    logic [4:0] t;
    t = cfg_type_i[c];
    return (c < `IFM_LOW_CHANS && (t == `IFM_TYPE_BAD_A || t == `IFM_TYPE_BAD_B)) // [R16]
        || (cfg_unity_eu_i[c] && (is_vi(t) || t == `IFM_TYPE_MV500)) // [R17]
        || (cfg_oc_en_i[c] && is_vi(t)); // [R18]
  endfunction

  function automatic logic code_ok(input logic [7:0] c);
    return (c >= `IFM_ERR_LO_A && c <= `IFM_ERR_HI_A) || c == `IFM_ERR_WDOG ||
           (c >= `IFM_ERR_LO_B && c <= `IFM_ERR_HI_B);
  endfunction

  // top nibble carries the flags, the rest reads zero [R9] [R10]
  function automatic logic [15:0] stat_word(input ifm_pkg::ifm_flags_t fl);
    return `IFM_STATUS_RESET | (16'(fl) << `IFM_FLG_LSB);
  endfunction

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    ifm_pkg::ifm_flags_t f;
    logic [4:0] t;
    logic tc;
    logic resistance_thermometer;
    logic go_flt;
    logic run;
    logic [7:0] code;
    f = '0;
    t = cfg_type_i[s_reg.ch];
    tc = t < `IFM_TYPE_RTD_LO;
    resistance_thermometer = !tc && t < `IFM_TYPE_MV500;
    go_flt = 1'b0;
    run = 1'b0;
    code = `IFM_ERR_LO_A;
    s_next = s_reg;
    s_next.smp = 1'b0;
    s_next.img_vld = 1'b0;
    s_next.serr_vld = 1'b0;
    mif.wr_en = 1'b0;
    mif.wr_addr = s_reg.ch;
    mif.wr_data = sample_data_i;
    mif.rd_en = 1'b0;
    mif.rd_addr = rd_chan_i;

    // one blink clock for every lamp, free running [R25]
    if (s_reg.bcnt == BW'(BLINK_CYC - 1)) begin
      s_next.bcnt = '0;
      s_next.blink = ~s_reg.blink;
    end else begin
      s_next.bcnt = s_reg.bcnt + BW'(1);
    end

    // enables: a new channel is checked at once, a dropped one is wiped
    s_next.en_q = chan_enable_i;
    for (int k = 0; k < 8; k++) begin
      if (!chan_enable_i[k]) begin
        s_next.flg[k] = '0; // [R8]
      end else if (!s_reg.en_q[k]) begin
        s_next.flg[k] = {cfg_bad(3'(k)), 3'h0}; // [R5]
      end
    end

    // scan results of the current channel
    f[`IFM_F_OPEN] = (cfg_oc_en_i[s_reg.ch] && oc_app(t) && sample_open_i) // [R11]
        || (resistance_thermometer && sample_ohms_i < `IFM_RTD_OPEN_OHMS) // [R13]
        || (tc && cold_junction_sensor_open_i); // [R24]
    f[`IFM_F_UNDER] = sample_under_i; // [R14]
    f[`IFM_F_OVER] = sample_over_i || (cfg_unity_eu_i[s_reg.ch] && cfg_fahr_i[s_reg.ch]
        && sample_eu_i > `IFM_EU_MAX); // [R15]
    f[`IFM_F_ERR] = cfg_bad(s_reg.ch) || sample_acq_bad_i || sample_autocal_fail_i; // [R19]

    case (s_reg.st)
      ifm_pkg::IFM_PWR: begin
        if (selftest_done_i) begin
          s_next.ch = '0;
          s_next.cnt = '0;
          if (selftest_fail_i) begin
            go_flt = 1'b1; // [R4]
          end else begin
            s_next.st = ifm_pkg::IFM_SET;
          end
        end
      end
      ifm_pkg::IFM_SET: begin
        if (!s_reg.en_q[s_reg.ch]) begin
          // disabled channels are passed over without settling
          s_next.ch = s_reg.ch + 3'h1;
          s_next.cnt = '0;
        end else if (s_reg.cnt == CW'(SETTLE_CYC - 1)) begin
          s_next.smp = 1'b1; // [R22]
          s_next.cnt = '0;
          s_next.st = ifm_pkg::IFM_WT;
        end else begin
          s_next.cnt = s_reg.cnt + CW'(1);
        end
      end
      ifm_pkg::IFM_WT: begin
        if (sample_valid_i) begin
          // whole nibble replaced at scan end, so stale flags drop [R7] [R26]
          if (s_reg.en_q[s_reg.ch] && chan_enable_i[s_reg.ch]) begin
            s_next.flg[s_reg.ch] = f; // [R6]
          end
          mif.wr_en = 1'b1;
          s_next.ch = s_reg.ch + 3'h1;
          s_next.cnt = '0;
          s_next.st = ifm_pkg::IFM_SET;
        end else if (s_reg.cnt == CW'(WDOG_CYC - 1)) begin
          go_flt = 1'b1;
          code = `IFM_ERR_WDOG;
        end else begin
          s_next.cnt = s_reg.cnt + CW'(1);
        end
      end
      ifm_pkg::IFM_FLT: begin
        // sweep zeros through every data word once [R20]
        if (!s_reg.clr[3]) begin
          mif.wr_en = 1'b1;
          mif.wr_addr = s_reg.clr[2:0];
          mif.wr_data = '0;
          s_next.clr = s_reg.clr + 4'h1;
        end
      end
      default: begin
        go_flt = 1'b1;
      end
    endcase

    // an outside fatal event wins; unknown codes fall back to the top of the first band
    if (fatal_i && s_reg.st != ifm_pkg::IFM_FLT) begin
      go_flt = 1'b1;
      code = code_ok(fatal_code_i) ? fatal_code_i : `IFM_ERR_HI_A;
    end
    if (go_flt) begin
      s_next.st = ifm_pkg::IFM_FLT;
      s_next.serr = {slot_i, code}; // [R21]
      s_next.serr_vld = 1'b1;
      s_next.clr = '0;
    end

    // image read: status or data per channel, two cycles either way [R23]
    s_next.rd_pend = 1'b0;
    if (rd_en_i && s_reg.st != ifm_pkg::IFM_FLT) begin
      s_next.rd_pend = 1'b1;
      s_next.rd_stat = cfg_status_sel_i[rd_chan_i];
      s_next.rd_ch = rd_chan_i;
      mif.rd_en = !cfg_status_sel_i[rd_chan_i];
    end
    if (s_reg.rd_pend) begin
      s_next.img_vld = 1'b1;
      s_next.img = s_reg.rd_stat ? stat_word(s_reg.flg[s_reg.rd_ch]) : mif.rd_data;
    end

    // a dead module answers nothing and holds every word at zero [R20]
    if (s_next.st == ifm_pkg::IFM_FLT) begin
      s_next.en_q = '0;
      s_next.flg = '0;
      s_next.img = '0;
      s_next.img_vld = 1'b0;
      s_next.rd_pend = 1'b0;
    end

    // lamps follow the registered flags of the same cycle
    run = s_next.st == ifm_pkg::IFM_SET || s_next.st == ifm_pkg::IFM_WT;
    s_next.mlamp = run; // [R1]
    for (int k = 0; k < 8; k++) begin
      s_next.lamp[k] = run && s_next.en_q[k]
          && (s_next.flg[k] == '0 || s_next.blink); // [R2] [R3]
    end
  end

  // ************************************************************
  // state register and outputs
  // ************************************************************
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s_reg <= '0;
      s_reg.st <= ifm_pkg::IFM_PWR;
    end else if (clk_en_i) begin
      s_reg <= s_next;
    end
  end

  assign mux_chan_o = s_reg.ch;
  assign mux_sample_o = s_reg.smp;
  assign image_word_o = s_reg.img;
  assign image_valid_o = s_reg.img_vld;
  assign mod_lamp_o = s_reg.mlamp;
  assign chan_lamp_o = s_reg.lamp;
  assign slot_error_o = s_reg.serr;
  assign slot_error_valid_o = s_reg.serr_vld;

  // data word store
  ifm_data_mem u_mem (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .clk_en_i(clk_en_i),
    .m(mif.mem)
  );

  // ************************************************************
  // checks
  // ************************************************************
  // settle counter kept apart from the sequencer so a slip shows
  logic [CW-1:0] chk_sc_reg;
  logic [2:0] chk_lc_reg;
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      chk_sc_reg <= '0;
      chk_lc_reg <= '0;
    end else if (clk_en_i) begin
      chk_sc_reg <= (s_reg.st == ifm_pkg::IFM_SET && s_reg.ch == chk_lc_reg) ?
          chk_sc_reg + CW'(1) : '0;
      chk_lc_reg <= s_reg.ch;
    end
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!reset_n_i);

  // scan taken on the current channel; one edge later chk_lc_reg names that channel
  sequence s_scan;
    clk_en_i && s_reg.st == ifm_pkg::IFM_WT && sample_valid_i
        && s_reg.en_q[s_reg.ch] && chan_enable_i[s_reg.ch] && !fatal_i;
  endsequence

  sequence s_clean;
    !sample_open_i && !sample_under_i && !sample_over_i && !sample_acq_bad_i
        && !sample_autocal_fail_i && !cold_junction_sensor_open_i
        && !cfg_bad(s_reg.ch) && sample_ohms_i >= `IFM_RTD_OPEN_OHMS && !cfg_fahr_i[s_reg.ch];
  endsequence

  a_fault_silent: assert property ( // [R1] [R20]
    s_reg.st == ifm_pkg::IFM_FLT |-> !mod_lamp_o && !image_valid_o && chan_lamp_o == '0
        && s_reg.flg == '0)
    else $error("fault state left a lamp or answer active");

  a_powerup_dark: assert property ( // [R3] [R4]
    s_reg.st == ifm_pkg::IFM_PWR |-> chan_lamp_o == '0 && !mod_lamp_o)
    else $error("lamp lit during power-up");

  a_disabled_dark: assert property ( // [R3]
    !s_reg.en_q[6] |-> !chan_lamp_o[6])
    else $error("disabled channel lamp lit");

  a_steady_ok: assert property ( // [R2]
    mod_lamp_o && s_reg.en_q[1] && s_reg.flg[1] == '0 |-> chan_lamp_o[1])
    else $error("healthy channel lamp not steady");

  a_blink_fault: assert property ( // [R6]
    mod_lamp_o && s_reg.en_q[2] && s_reg.flg[2] != '0 |-> chan_lamp_o[2] == s_reg.blink)
    else $error("faulted channel lamp not blinking");

  a_disable_clears: assert property ( // [R8]
    clk_en_i && !chan_enable_i[6] |=> s_reg.flg[6] == '0)
    else $error("flags kept after enable cleared");

  a_settle_time: assert property ( // [R22]
    mux_sample_o |-> chk_sc_reg >= CW'(SETTLE_CYC - 1) && $stable(mux_chan_o))
    else $error("sample before settling time");

  a_slot_code: assert property ( // [R21]
    slot_error_valid_o |-> code_ok(slot_error_o[7:0]) && s_reg.st == ifm_pkg::IFM_FLT)
    else $error("slot error code outside module set");

  a_bad_type: assert property ( // [R16]
    s_scan and (s_reg.ch < `IFM_LOW_CHANS && cfg_type_i[s_reg.ch] == `IFM_TYPE_BAD_A)
        |=> s_reg.flg[chk_lc_reg][`IFM_F_ERR])
    else $error("invalid input type not flagged");

  a_self_clear: assert property ( // [R7]
    s_scan and s_clean |=> s_reg.flg[chk_lc_reg] == '0 && chan_lamp_o[chk_lc_reg])
    else $error("fault flags did not clear");

  a_cjc_open: assert property ( // [R24]
    s_scan and (cold_junction_sensor_open_i && cfg_type_i[s_reg.ch] < `IFM_TYPE_RTD_LO)
        |=> s_reg.flg[chk_lc_reg][`IFM_F_OPEN])
    else $error("thermocouple not opened by cold junction fault");

  a_over_range: assert property ( // [R15]
    s_scan and (cfg_unity_eu_i[s_reg.ch] && cfg_fahr_i[s_reg.ch] && sample_eu_i > `IFM_EU_MAX)
        |=> s_reg.flg[chk_lc_reg][`IFM_F_OVER])
    else $error("Fahrenheit overflow not flagged");
endmodule

// ===== rtl/ifm_map.svh
// offsets, field positions, codes and timing of the input channel fault monitor
`ifndef IFM_MAP_SVH
`define IFM_MAP_SVH
// ************************************************************
// status word layout: four fault flags in the top nibble
// ************************************************************
`define IFM_FLG_LSB 12
`define IFM_F_OPEN 0
`define IFM_F_UNDER 1
`define IFM_F_OVER 2
`define IFM_F_ERR 3
`define IFM_STATUS_RESET 16'h0000
// ************************************************************
// input type codes
// ************************************************************
`define IFM_TYPE_RTD_LO 5'h0A
`define IFM_TYPE_MV500 5'h10
`define IFM_TYPE_PM2V 5'h11
`define IFM_TYPE_BAD_A 5'h12
`define IFM_TYPE_V0_5 5'h13
`define IFM_TYPE_V1_5 5'h14
`define IFM_TYPE_V0_10 5'h15
`define IFM_TYPE_PM10V 5'h16
`define IFM_TYPE_MA0_20 5'h17
`define IFM_TYPE_BAD_B 5'h1D
`define IFM_LOW_CHANS 3'h4
// ************************************************************
// slot error codes and limits
// ************************************************************
`define IFM_ERR_LO_A 8'h50
`define IFM_ERR_HI_A 8'h5E
`define IFM_ERR_WDOG 8'h71
`define IFM_ERR_LO_B 8'h90
`define IFM_ERR_HI_B 8'h94
`define IFM_RTD_OPEN_OHMS 16'h0003
`define IFM_EU_MAX 20'sh07FFF
// ************************************************************
// timing
// ************************************************************
`define IFM_CLK_MHZ 200
`define IFM_SETTLE_US 3000
`define IFM_SETTLE_CYC (`IFM_SETTLE_US * `IFM_CLK_MHZ)
`define IFM_BLINK_HALF_MS 500
`define IFM_BLINK_CYC (`IFM_BLINK_HALF_MS * 1000 * `IFM_CLK_MHZ)
`define IFM_WDOG_US 5000
`define IFM_WDOG_CYC (`IFM_WDOG_US * `IFM_CLK_MHZ)
`define IFM_CNT_W 20
`define IFM_BLK_W 27
`endif

// ===== rtl/ifm_mem_if.sv
// data-word store port between the monitor and its memory
`timescale 1ns/10ps
interface ifm_mem_if;
  logic wr_en;
  logic [2:0] wr_addr;
  logic [15:0] wr_data;
  logic rd_en;
  logic [2:0] rd_addr;
  logic [15:0] rd_data;
  modport ctrl (output wr_en, wr_addr, wr_data, rd_en, rd_addr, input rd_data);
  modport mem (input wr_en, wr_addr, wr_data, rd_en, rd_addr, output rd_data);
endinterface

// ===== rtl/ifm_pkg.sv
// types of the input channel fault monitor
`include "ifm_map.svh"
package ifm_pkg;
  typedef enum logic [3:0] {
    IFM_PWR = 4'h1,
    IFM_SET = 4'h2,
    IFM_WT = 4'h4,
    IFM_FLT = 4'h8
  } ifm_state_e;
  // {error, over, under, open}
  typedef logic [3:0] ifm_flags_t;
  typedef struct packed {
    ifm_state_e st;
    logic [2:0] ch;
    logic [`IFM_CNT_W-1:0] cnt;
    logic [`IFM_BLK_W-1:0] bcnt;
    logic blink;
    logic [7:0] en_q;
    ifm_flags_t [7:0] flg;
    logic [3:0] clr;
    logic rd_pend;
    logic rd_stat;
    logic [2:0] rd_ch;
    logic [15:0] img;
    logic img_vld;
    logic smp;
    logic [7:0] lamp;
    logic mlamp;
    logic [15:0] serr;
    logic serr_vld;
  } ifm_state_s;
  typedef struct packed {
    logic [7:0][15:0] word;
    logic [15:0] rdata;
  } ifm_mem_s;
endpackage
